// File: logic/hpc_pkg.sv
// Package: register map, field layout, event and state types of the power controller
package hpc_pkg;

    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          IDX_W         = 6;
    localparam int          NUM_EV        = 7;

    // Register byte addresses
    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_LOWBAT   = 8'h04;
    localparam logic [7:0]  ADDR_EV_EN    = 8'h08;
    localparam logic [7:0]  ADDR_EV_RAW   = 8'h0c;
    localparam logic [7:0]  ADDR_EV_MASK  = 8'h10;
    localparam logic [7:0]  ADDR_EV_CLR   = 8'h14;
    localparam logic [7:0]  ADDR_CNT      = 8'h18;
    localparam logic [7:0]  ADDR_MATCH    = 8'h1c;

    // Control register fields
    localparam int          CTRL_ACTIVE   = 0;
    localparam int          CTRL_RTC_EN   = 1;
    localparam int          CTRL_HIB_REQ  = 2;
    localparam int          CTRL_WAKE_LSB = 3;
    localparam int          WAKE_W        = 4;
    localparam int          CTRL_REG_ON   = 8;

    // Wake enable bits inside the wake field
    localparam int          WK_PIN        = 0;
    localparam int          WK_MATCH      = 1;
    localparam int          WK_RST        = 2;
    localparam int          WK_GPIO       = 3;

    // Low-battery register fields
    localparam int          LB_DETECT     = 0;
    localparam int          LB_ABORT      = 1;
    localparam int          LB_LVL_LSB    = 2;
    localparam int          LB_LVL_W      = 2;
    localparam int          BAT_LVLS      = 4;
    localparam logic [1:0]  BATTERY_TRIP_LVL0 = 2'h0;
    localparam logic [1:0]  BATTERY_TRIP_LVL1 = 2'h1;
    localparam logic [1:0]  BATTERY_TRIP_LVL2 = 2'h2;
    localparam logic [1:0]  BATTERY_TRIP_LVL3 = 2'h3;

    // Event flag positions
    localparam int          EV_WR_DONE    = 0;
    localparam int          EV_PIN_WAKE   = 1;
    localparam int          EV_BATTERY_LOW = 2;
    localparam int          EV_MATCH0     = 3;
    localparam int          EV_SUPPLY_FAIL = 4;
    localparam int          EV_RST_WAKE   = 5;
    localparam int          EV_GPIO_WAKE  = 6;

    // Synchroniser lanes
    localparam int          SY_PIN        = 0;
    localparam int          SY_SUPPLY     = 1;
    localparam int          SY_RST        = 2;
    localparam int          SY_GPIO       = 3;
    localparam int          SY_TICK       = 4;
    localparam int          SY_BAT_LSB    = 5;
    localparam int          SYNC_W        = 9;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    localparam logic [31:0] CNT_STEP      = 32'h0000_0001;

    typedef enum logic { HPC_PWR_ON, HPC_PWR_OFF } hpc_pwr_t;

    typedef struct packed {
        logic                awvalid;
        logic [ADDR_W-1:0]   awaddr;
        logic                wvalid;
        logic [DATA_W-1:0]   wdata;
        logic [3:0]          wstrb;
        logic                bready;
        logic                arvalid;
        logic [ADDR_W-1:0]   araddr;
        logic                rready;
    } hpc_axi_req_t;

    typedef struct packed {
        logic                awready;
        logic                wready;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                arready;
        logic                rvalid;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          rresp;
    } hpc_axi_rsp_t;

    typedef struct packed {
        logic [SYNC_W-1:0]   s1;
        logic [SYNC_W-1:0]   s2;
        logic [SYNC_W-1:0]   s3;
        logic                aw_rdy;
        logic                w_rdy;
        logic                aw_got;
        logic                w_got;
        logic [ADDR_W-1:0]   awaddr;
        logic [DATA_W-1:0]   wdata;
        logic [3:0]          wstrb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                ar_rdy;
        logic                rvalid;
        logic [DATA_W-1:0]   rdata;
        logic [1:0]          rresp;
        logic                active;
        logic                rtc_en;
        logic [WAKE_W-1:0]   wake_en;
        logic                battery_detect_on;
        logic                battery_abort_on;
        logic [LB_LVL_W-1:0] bat_lvl;
        logic [NUM_EV-1:0]   ev_en;
        logic [NUM_EV-1:0]   raw;
        logic [DATA_W-1:0]   rtc_cnt;
        logic [DATA_W-1:0]   match;
        hpc_pwr_t            pwr;
        logic                regulator_en;
        logic                event_out;
    } hpc_state_t;

    // Byte-lane merge of a write into the current register value
    function automatic logic [DATA_W-1:0] hpc_merge(input logic [DATA_W-1:0] old_v,
                                                    input logic [DATA_W-1:0] new_v,
                                                    input logic [3:0]        strb);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

endpackage

// File: logic/hpc_power_ctrl.sv
// Hibernation power controller: regulator control, event flags, battery check, AXI4-Lite slave
// Operation
// - Seven event sources, each with its own enable, any combination allowed.
// - Clear write drops selected pending flags; uncleared enabled flags keep event output high.
// - Flags readable raw, or masked by their enable bits.
// - Disabling a source stops only that source from being forwarded.
// - Event output asserts only for individually enabled sources.
// - Readable active bit in control survives processor power-on reset.
// - Raw flags are kept across hibernation to reveal the wake cause.
// - With detection on, low battery sets its raw flag.
// - Abort option: low battery at request cancels hibernation, regulator stays on.
// - Two-bit threshold select chooses one of four battery trip levels.
// - Battery detection mode and threshold read back.
// - Hibernation request with the active bit set drops the regulator enable; this logic stays powered.
// - Any enabled wake condition raises the regulator enable again.
// - Processor power-on reset does not touch this block's state.
// - Counter disabled stops counting, matching and counter wake.
// - Reset-pin, gpio-pin and supply-fail sources are build-time optional.
// - Counter equal to match raises match event and may wake.
`timescale 1ns/1ps

module hpc_power_ctrl
    import hpc_pkg::*;
#(
    parameter bit HAS_SUPPLY_FAIL = 1'b1,
    parameter bit HAS_RST_WAKE    = 1'b1,
    parameter bit HAS_GPIO_WAKE   = 1'b1
) (
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic                ce,
    input  wire hpc_axi_req_t        axi_req,
    output hpc_axi_rsp_t             axi_rsp,
    input  wire logic                wake_pin,
    input  wire logic                supply_fail,
    input  wire logic                reset_pin_wake,
    input  wire logic                gpio_wake,
    input  wire logic                sec_tick,
    input  wire logic [BAT_LVLS-1:0] battery_below,
    output logic                     regulator_en,
    output logic                     event_out
);

    hpc_state_t        st;
    hpc_state_t        nx;

    logic [SYNC_W-1:0] async_in;
    logic [SYNC_W-1:0] rise;
    logic [NUM_EV-1:0] present;
    logic [NUM_EV-1:0] set_vec;
    logic [NUM_EV-1:0] clr_vec;
    logic [NUM_EV-1:0] clr_only;
    logic [NUM_EV-1:0] raw_next;
    logic [BAT_LVLS-1:0] bat_cmp;
    logic              bat_low;
    logic              commit;
    logic              aw_hs;
    logic              w_hs;
    logic              ar_hs;
    logic              wr_known;
    logic [DATA_W-1:0] wv;
    logic [DATA_W-1:0] rd_val;
    logic              rd_known;
    logic              req_commit;
    logic              abort_cond;
    logic              hib_go;
    logic              tick;
    logic [DATA_W-1:0] cnt_inc;
    logic              match_hit;
    logic              cnt_wr;
    logic              wake_hit;

    // Register read view shared by reads and byte-lane merges of writes
    function automatic logic [DATA_W-1:0] reg_value(input hpc_state_t s,
                                                    input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = '0;
        case ({a[ADDR_W-1:2], 2'h0})
            ADDR_CTRL: begin
                v[CTRL_ACTIVE] = s.active;
                v[CTRL_RTC_EN] = s.rtc_en;
                v[CTRL_WAKE_LSB +: WAKE_W] = s.wake_en;
                v[CTRL_REG_ON] = s.regulator_en;
            end
            ADDR_LOWBAT: begin
                v[LB_DETECT] = s.battery_detect_on;
                v[LB_ABORT] = s.battery_abort_on;
                v[LB_LVL_LSB +: LB_LVL_W] = s.bat_lvl;
            end
            ADDR_EV_EN: v[NUM_EV-1:0] = s.ev_en;
            ADDR_EV_RAW: v[NUM_EV-1:0] = s.raw;
            ADDR_EV_MASK: v[NUM_EV-1:0] = s.raw & s.ev_en;
            ADDR_CNT: v = s.rtc_cnt;
            ADDR_MATCH: v = s.match;
            default: v = '0;
        endcase
        return v;
    endfunction

    function automatic logic addr_known(input logic [ADDR_W-1:0] a);
        logic k;
        case ({a[ADDR_W-1:2], 2'h0})
            ADDR_CTRL, ADDR_LOWBAT, ADDR_EV_EN, ADDR_EV_RAW,
            ADDR_EV_MASK, ADDR_EV_CLR, ADDR_CNT, ADDR_MATCH: k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction

    // Pins cross in through two flops; levels come from the second stage, edges from the second and third
    assign async_in = {battery_below, sec_tick, gpio_wake, reset_pin_wake,
                       supply_fail, wake_pin};
    assign rise     = st.s2 & ~st.s3;

    // AXI handshakes and the single write commit point
    assign aw_hs    = axi_req.awvalid & st.aw_rdy;
    assign w_hs     = axi_req.wvalid & st.w_rdy;
    assign ar_hs    = axi_req.arvalid & st.ar_rdy;
    assign commit   = st.aw_got & st.w_got & ~st.bvalid;
    assign wr_known = addr_known(st.awaddr);
    assign wv       = hpc_merge(reg_value(st, st.awaddr), st.wdata, st.wstrb);
    assign rd_val   = reg_value(st, axi_req.araddr);
    assign rd_known = addr_known(axi_req.araddr);

    // Request is a one-shot bit; it never reads back as set
    assign req_commit = commit && ({st.awaddr[ADDR_W-1:2], 2'h0} == ADDR_CTRL)
                        && wv[CTRL_HIB_REQ];
    assign cnt_wr     = commit && ({st.awaddr[ADDR_W-1:2], 2'h0} == ADDR_CNT);

    assign bat_cmp    = st.s2[SY_BAT_LSB +: BAT_LVLS];
    assign bat_low    = bat_cmp[st.bat_lvl];
    assign abort_cond = req_commit && st.battery_abort_on && bat_low;
    assign hib_go     = req_commit && st.active && !abort_cond && (st.pwr == HPC_PWR_ON);

    assign tick      = rise[SY_TICK] & st.rtc_en;
    assign cnt_inc   = st.rtc_cnt + CNT_STEP;
    assign match_hit = tick && (cnt_inc == st.match);

    assign wake_hit = (st.wake_en[WK_PIN] & rise[SY_PIN])
                    | (st.wake_en[WK_MATCH] & match_hit)
                    | (st.wake_en[WK_RST] & rise[SY_RST] & HAS_RST_WAKE)
                    | (st.wake_en[WK_GPIO] & rise[SY_GPIO] & HAS_GPIO_WAKE);

    always_comb begin
        set_vec                 = '0;
        set_vec[EV_WR_DONE]     = commit;
        set_vec[EV_PIN_WAKE]    = rise[SY_PIN];
        set_vec[EV_BATTERY_LOW] = (st.battery_detect_on & bat_low) | abort_cond;
        set_vec[EV_MATCH0]      = match_hit;
        set_vec[EV_SUPPLY_FAIL] = rise[SY_SUPPLY];
        set_vec[EV_RST_WAKE]    = rise[SY_RST];
        set_vec[EV_GPIO_WAKE]   = rise[SY_GPIO];
    end

    assign clr_vec  = (commit && ({st.awaddr[ADDR_W-1:2], 2'h0} == ADDR_EV_CLR))
                      ? wv[NUM_EV-1:0] : '0;
    assign clr_only = clr_vec & ~set_vec;

    always_comb begin
        present                 = '1;
        present[EV_SUPPLY_FAIL] = HAS_SUPPLY_FAIL;
        present[EV_RST_WAKE]    = HAS_RST_WAKE;
        present[EV_GPIO_WAKE]   = HAS_GPIO_WAKE;
    end

    generate
        for (genvar i = 0; i < NUM_EV; i++) begin : g_flag
            assign raw_next[i] = present[i] & (set_vec[i] | (st.raw[i] & ~clr_vec[i]));
        end
    endgenerate

    always_comb begin
        nx        = st;
        nx.s1     = async_in;
        nx.s2     = st.s1;
        nx.s3     = st.s2;
        nx.raw    = raw_next;

        // Write channel: address and data taken in either order
        if (aw_hs) begin
            nx.aw_got = 1'b1;
            nx.aw_rdy = 1'b0;
            nx.awaddr = axi_req.awaddr;
        end
        if (w_hs) begin
            nx.w_got = 1'b1;
            nx.w_rdy = 1'b0;
            nx.wdata = axi_req.wdata;
            nx.wstrb = axi_req.wstrb;
        end
        if (commit) begin
            nx.bvalid = 1'b1;
            nx.bresp  = wr_known ? RESP_OKAY : RESP_SLVERR;
            case ({st.awaddr[ADDR_W-1:2], 2'h0})
                ADDR_CTRL: begin
                    nx.active  = wv[CTRL_ACTIVE];
                    nx.rtc_en  = wv[CTRL_RTC_EN];
                    nx.wake_en = wv[CTRL_WAKE_LSB +: WAKE_W];
                end
                ADDR_LOWBAT: begin
                    nx.battery_detect_on = wv[LB_DETECT];
                    nx.battery_abort_on  = wv[LB_ABORT];
                    nx.bat_lvl           = wv[LB_LVL_LSB +: LB_LVL_W];
                end
                ADDR_EV_EN: nx.ev_en = wv[NUM_EV-1:0];
                ADDR_MATCH: nx.match = wv;
                default: nx.match = st.match;
            endcase
        end
        if (st.bvalid && axi_req.bready) begin
            nx.bvalid = 1'b0;
            nx.aw_got = 1'b0;
            nx.w_got  = 1'b0;
            nx.aw_rdy = 1'b1;
            nx.w_rdy  = 1'b1;
        end

        // Read channel: one read in flight, answered the cycle after address
        if (ar_hs) begin
            nx.ar_rdy = 1'b0;
            nx.rvalid = 1'b1;
            nx.rdata  = rd_val;
            nx.rresp  = rd_known ? RESP_OKAY : RESP_SLVERR;
        end
        if (st.rvalid && axi_req.rready) begin
            nx.rvalid = 1'b0;
            nx.ar_rdy = 1'b1;
        end

        // Software write of the counter beats the tick in the same cycle
        if (cnt_wr) begin
            nx.rtc_cnt = wv;
        end else if (tick) begin
            nx.rtc_cnt = cnt_inc;
        end

        case (st.pwr)
            HPC_PWR_ON: begin
                if (hib_go) begin
                    nx.pwr          = HPC_PWR_OFF;
                    nx.regulator_en = 1'b0;
                end
            end
            HPC_PWR_OFF: begin
                if (wake_hit) begin
                    nx.pwr          = HPC_PWR_ON;
                    nx.regulator_en = 1'b1;
                end
            end
            default: begin
                nx.pwr          = HPC_PWR_ON;
                nx.regulator_en = 1'b1;
            end
        endcase

        nx.event_out = |(raw_next & nx.ev_en);
    end

    // only the always-on reset clears this state, not processor reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st              <= '0;
            st.pwr          <= HPC_PWR_ON;
            st.regulator_en <= 1'b1;
            st.aw_rdy       <= 1'b1;
            st.w_rdy        <= 1'b1;
            st.ar_rdy       <= 1'b1;
        end else if (ce) begin
            st <= nx;
        end
    end

    assign axi_rsp.awready = st.aw_rdy;
    assign axi_rsp.wready  = st.w_rdy;
    assign axi_rsp.bvalid  = st.bvalid;
    assign axi_rsp.bresp   = st.bresp;
    assign axi_rsp.arready = st.ar_rdy;
    assign axi_rsp.rvalid  = st.rvalid;
    assign axi_rsp.rdata   = st.rdata;
    assign axi_rsp.rresp   = st.rresp;
    assign regulator_en    = st.regulator_en;
    assign event_out       = st.event_out;

    default clocking hpc_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence hib_req_s;
        ce && req_commit;
    endsequence

    sequence low_batt_s;
        st.battery_abort_on && bat_low;
    endsequence

    sequence asleep_s;
        ce && (st.pwr == HPC_PWR_OFF) && !regulator_en;
    endsequence

    // Event output always equals the OR of enabled raw flags
    event_gate_a: assert property (event_out == |(st.raw & st.ev_en))
        else $error("event output differs from masked flags");

    // A clear of a bit with no fresh event empties it
    flag_clear_a: assert property ((ce && clr_only != '0) |=> (st.raw & $past(clr_only)) == '0)
        else $error("cleared flag still pending");

    // Any set event of a present source reaches the raw flags, even during a clear
    flag_set_a: assert property ((ce && (set_vec & present) != '0)
                                 |=> (st.raw & $past(set_vec & present)) == $past(set_vec & present))
        else $error("event did not set its flag");

    // Aborted request keeps power and sets the battery flag
    abort_keep_a: assert property (hib_req_s ##0 low_batt_s
                                   |=> regulator_en && st.raw[EV_BATTERY_LOW])
        else $error("low battery abort did not hold power");

    // Accepted request drops the regulator one cycle later and enters the off state
    hib_drop_a: assert property ((ce && hib_go) |=> !regulator_en && st.pwr == HPC_PWR_OFF)
        else $error("hibernation request did not drop regulator");

    // Enabled wake while off restores regulator next cycle
    wake_up_a: assert property (asleep_s ##0 wake_hit |=> regulator_en)
        else $error("wake did not restore regulator");

    // Without a wake the regulator stays off
    stay_off_a: assert property (asleep_s ##0 !wake_hit |=> !regulator_en)
        else $error("regulator rose without wake");

    // Disabled counter holds still and never matches
    cnt_freeze_a: assert property ((ce && !st.rtc_en && !cnt_wr)
                                   |=> $stable(st.rtc_cnt) && !$past(match_hit))
        else $error("counter moved while disabled");

    // Detection with low battery sets the flag
    batt_detect_a: assert property ((ce && st.battery_detect_on && bat_low)
                                    |=> st.raw[EV_BATTERY_LOW])
        else $error("low battery not flagged");

    // Absent sources never show a flag
    opt_source_a: assert property ((st.raw & ~present) == '0)
        else $error("absent source flagged");

    // Write response held until taken
    bresp_hold_a: assert property ((axi_rsp.bvalid && !axi_req.bready) |=> axi_rsp.bvalid)
        else $error("write response dropped early");

endmodule

// File: tb/hpc_power_ctrl_test.sv
// Testbench: register-level checks of the hibernation power controller
`timescale 1ns/1ps
module hpc_power_ctrl_test;
    import hpc_pkg::*;
    logic                aclk, aresetn, ce, sec_tick, wake_cmd, wake_pin;
    logic                regulator_en, event_out;
    logic [2:0]          misc;
    logic [BAT_LVLS-1:0] battery_below;
    hpc_axi_req_t        req;
    hpc_axi_rsp_t        rsp;
    logic [31:0]         rdat, m;
    logic [1:0]          rr, lvl;
    int                  error_cnt, n_compared, cyc;

    hpc_power_ctrl dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .axi_req(req),
        .axi_rsp(rsp), .wake_pin(wake_pin), .supply_fail(misc[0]),
        .reset_pin_wake(misc[1]), .gpio_wake(misc[2]), .sec_tick(sec_tick),
        .battery_below(battery_below), .regulator_en(regulator_en), .event_out(event_out));
    hpc_wake_model far (.aclk(aclk), .wake_cmd(wake_cmd), .wake_pin(wake_pin));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic complete_run();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Hang guard: the full sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Address and data offered together, each dropped once taken; bready stays high
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= 4'hf;
        do begin
            @(posedge aclk);
            if (rsp.awready === 1'b1) req.awvalid <= 1'b0;
            if (rsp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (rsp.bvalid !== 1'b1);
    endtask

    task automatic rd(input logic [7:0] a);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        do @(posedge aclk); while (rsp.arready !== 1'b1);
        req.arvalid <= 1'b0;
        do @(posedge aclk); while (rsp.rvalid !== 1'b1);
        rdat = rsp.rdata;
        rr = rsp.rresp;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rdat, exp);
    endtask

    task automatic wake();
        wake_cmd <= 1'b1;
        @(posedge aclk);
        wake_cmd <= 1'b0;
        repeat (10) @(posedge aclk);
    endtask

    task automatic tick();
        sec_tick <= 1'b1;
        repeat (3) @(posedge aclk);
        sec_tick <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    initial begin
        void'($urandom(79392));
        aresetn = 1'b0;
        ce = 1'b1;
        sec_tick = 1'b0;
        wake_cmd = 1'b0;
        misc = 3'h0;
        battery_below = '0;
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
        error_cnt = 0;
        n_compared = 0;
        cyc = 0;
        lvl = 2'($urandom);
        m = $urandom;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(ADDR_CTRL, 32'h100);
        rchk(ADDR_EV_EN, 32'h0);
        wr(ADDR_LOWBAT, {28'h0, lvl, 2'b01});
        rchk(ADDR_LOWBAT, {28'h0, lvl, 2'b01});
        wr(ADDR_EV_EN, 32'h2);
        wr(ADDR_EV_CLR, 32'h7f);
        wake();
        chk({31'h0, event_out}, 32'h1);
        rchk(ADDR_EV_MASK, 32'h2);
        rchk(ADDR_EV_RAW, 32'h3);
        wr(ADDR_EV_CLR, 32'h2);
        repeat (2) @(posedge aclk);
        chk({31'h0, event_out}, 32'h0);
        rchk(ADDR_EV_RAW, 32'h1);
        // Frozen clock enable must miss a whole pin pulse
        ce <= 1'b0;
        wake();
        ce <= 1'b1;
        rchk(ADDR_EV_RAW, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_EV_CLR, 32'h7f);
            misc <= 3'b001 << i;
            repeat (6) @(posedge aclk);
            misc <= 3'h0;
            rchk(ADDR_EV_RAW, 32'h1 | (32'h10 << i));
        end
        wr(ADDR_CTRL, 32'h9);
        wr(ADDR_EV_CLR, 32'h7f);
        wr(ADDR_CTRL, 32'hd);
        chk({31'h0, regulator_en}, 32'h0);
        rchk(ADDR_CTRL, 32'h9);
        wake();
        chk({31'h0, regulator_en}, 32'h1);
        rchk(ADDR_CTRL, 32'h109);
        rchk(ADDR_EV_RAW, 32'h3);
        battery_below[lvl] <= 1'b1;
        wr(ADDR_LOWBAT, {28'h0, lvl, 2'b10});
        wr(ADDR_EV_CLR, 32'h7f);
        wr(ADDR_CTRL, 32'hd);
        chk({31'h0, regulator_en}, 32'h1);
        rchk(ADDR_EV_RAW, 32'h5);
        wr(ADDR_LOWBAT, {28'h0, lvl, 2'b01});
        wr(ADDR_EV_CLR, 32'h7f);
        rchk(ADDR_EV_RAW, 32'h5);
        battery_below <= '0;
        wr(ADDR_LOWBAT, 32'h0);
        wr(ADDR_CTRL, 32'h9);
        wr(ADDR_CNT, 32'h5);
        tick();
        rchk(ADDR_CNT, 32'h5);
        wr(ADDR_CNT, m - 32'h1);
        wr(ADDR_MATCH, m);
        wr(ADDR_CTRL, 32'h13);
        wr(ADDR_EV_CLR, 32'h7f);
        wr(ADDR_CTRL, 32'h17);
        chk({31'h0, regulator_en}, 32'h0);
        tick();
        chk({31'h0, regulator_en}, 32'h1);
        rchk(ADDR_EV_RAW, 32'h9);
        rd(8'h40);
        chk(rdat, 32'h0);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR});
        complete_run();
    end
endmodule

// File: tb/hpc_wake_model.sv
// Far-side model: wake push-button line feeding the controller
`timescale 1ns/1ps
module hpc_wake_model (
    input  wire logic aclk,
    input  wire logic wake_cmd,
    output logic      wake_pin
);
    logic [2:0] hold = 3'h0;
    // Pull-down keeps the idle line low; a press lasts four cycles to beat the synchroniser
    always_ff @(posedge aclk) begin
        if (wake_cmd) begin
            hold <= 3'h4;
        end else if (hold != 3'h0) begin
            hold <= hold - 3'h1;
        end
    end
    assign wake_pin = (hold != 3'h0);
endmodule
